// ===== logic/seq_pkg.sv
/* seq_pkg: register map, field widths, reset values and layer encoding
   for the arm/trigger acquisition sequencer.
   assumes: a 32-bit apb slave with byte addresses in paddr[7:0]. */
package seq_pkg;
   // widths
   localparam int CNT_W = 8;
   localparam int DLY_W = 16;
   localparam int DATA_W = 16;
   localparam int DEPTH_W = 6;
   localparam int CHANS = 8;
   localparam int LINES = 16;
   localparam int BANK_W = 8;

   // register byte offsets
   localparam logic [7:0] A_CONFIG = 8'h00;
   localparam logic [7:0] A_COMMAND = 8'h04;
   localparam logic [7:0] A_ARM_COUNT = 8'h08;
   localparam logic [7:0] A_TRIGGER_PASS_COUNT = 8'h0C;
   localparam logic [7:0] A_ARM_DELAY = 8'h10;
   localparam logic [7:0] A_TRIG_DELAY = 8'h14;
   localparam logic [7:0] A_SAMPLE_COUNT = 8'h18;
   localparam logic [7:0] A_SCAN_LIST = 8'h1C;
   localparam logic [7:0] A_LINE_DRIVE = 8'h20;
   localparam logic [7:0] A_ARM_SOURCE = 8'h24;
   localparam logic [7:0] A_TRIG_SOURCE = 8'h28;
   localparam logic [7:0] A_STATUS = 8'h2C;
   localparam logic [7:0] A_LINE_IN = 8'h30;
   localparam logic [7:0] A_BUF_DATA = 8'h34;

   // config bits
   localparam int CFG_W = 5;
   localparam int CFG_REARM = 0;
   localparam int CFG_DIR0 = 1;
   localparam int CFG_DIR1 = 2;
   localparam int CFG_ACT0 = 3;
   localparam int CFG_ACT1 = 4;

   // command bits, write one to issue
   localparam int CMD_INIT = 0;
   localparam int CMD_ARM = 1;
   localparam int CMD_TRIG = 2;

   // reset values
   localparam logic [CFG_W-1:0] CONFIG_RST = 5'h00;
   localparam logic [CNT_W-1:0] PASS_RST = 8'h01;
   localparam logic [DLY_W-1:0] DELAY_RST = 16'h0000;
   localparam logic [CNT_W-1:0] SAMPLE_RST = 8'h01;
   localparam logic [CHANS-1:0] SCAN_RST = 8'h01;
   localparam logic [LINES-1:0] LINE_RST = 16'h0000;

   typedef enum logic [2:0] {
      IDLE, INIT, ARM_WAIT, ARM_DELAY, TRIG_WAIT, TRIG_DELAY, ACQUIRE
   } layer_t;
endpackage

// ===== logic/sample_mem.sv
/* sample_mem: single-port-write, registered-read sample buffer store.
   assumes: one clock; read data appears one edge after the address. */
`timescale 1ns/1ps
module sample_mem (
   // clock
   input wire logic pclk,
   // write side
   input wire logic wr_en,
   input wire logic [seq_pkg::DEPTH_W-1:0] wr_addr,
   input wire logic [seq_pkg::DATA_W-1:0] wr_data,
   // read side
   input wire logic [seq_pkg::DEPTH_W-1:0] rd_addr,
   output logic [seq_pkg::DATA_W-1:0] rd_data
);
   logic [seq_pkg::DATA_W-1:0] mem [0:(1<<seq_pkg::DEPTH_W)-1];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== logic/arm_trigger_sequencer.sv
/* arm_trigger_sequencer: apb-controlled arm/trigger acquisition sequencer
   with a sample buffer and two banks of digital lines.
   assumes: pclk 200 MHz, presetn async low; converter results arrive
   free-running as adc_valid pulses tagged with their channel. */
// Notes on behaviour
// - after reset rest idle, no acquisition until initialize
// - initialize passes through init into arm and clears the buffer
// - arm pass count reloads on entering arm from init
// - arm layer waits for selected arm event or software arm
// - then wait arm delay, decrement arm count, enter trigger layer
// - entering trigger from arm reloads the trigger pass count
// - trigger layer waits for trigger event or software trigger
// - then wait trigger delay, decrement trigger count, enter acquire
// - acquire measures each scanned channel sample-count times into buffer
// - trigger count nonzero after acquire: back to trigger wait, no reload
// - trigger count zero, arm count nonzero: re-enter arm layer
// - arm count zero returns to init; auto-rearm re-enters arm, no clear
// - auto-rearm off: init goes idle awaiting new initialize
// - sixteen lines in two banks of eight
// - bank direction set per bank, input after reset
// - output bank selects passive or active pull-up drive
// - input lines may act as arm source, trigger source, or both
// - samples outside acquire are taken but discarded
`timescale 1ns/1ps
module arm_trigger_sequencer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter results
   input wire logic adc_valid,
   input wire logic [2:0] adc_chan,
   input wire logic [seq_pkg::DATA_W-1:0] adc_data,
   // digital lines
   input wire logic [seq_pkg::LINES-1:0] digital_line_in,
   output logic [seq_pkg::LINES-1:0] digital_line_out,
   output logic [seq_pkg::LINES-1:0] digital_line_oe
);
   function automatic logic [seq_pkg::CNT_W-1:0] dec(input logic [seq_pkg::CNT_W-1:0] v);
      dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
   endfunction

   function automatic logic at(input logic [7:0] a, input logic [7:0] off);
      at = (a == off);
   endfunction

   // bus handshake
   logic wr;
   logic rd;
   logic hit;
   logic [31:0] rd_word;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   // configuration
   logic [seq_pkg::CFG_W-1:0] cfg, next_cfg;
   logic [seq_pkg::CNT_W-1:0] arm_count, next_arm_count;
   logic [seq_pkg::CNT_W-1:0] trigger_pass_count, next_trigger_pass_count;
   logic [seq_pkg::DLY_W-1:0] arm_delay, next_arm_delay;
   logic [seq_pkg::DLY_W-1:0] trig_delay, next_trig_delay;
   logic [seq_pkg::CNT_W-1:0] sample_count, next_sample_count;
   logic [seq_pkg::CHANS-1:0] scan_list, next_scan_list;
   logic [seq_pkg::LINES-1:0] line_drive, next_line_drive;
   logic [seq_pkg::LINES-1:0] arm_source, next_arm_source;
   logic [seq_pkg::LINES-1:0] trig_source, next_trig_source;
   logic cmd_init;
   logic cmd_arm;
   logic cmd_trig;

   // sequencer
   seq_pkg::layer_t layer, next_layer;
   logic [seq_pkg::CNT_W-1:0] arm_left, next_arm_left;
   logic [seq_pkg::CNT_W-1:0] trig_left, next_trig_left;
   logic [seq_pkg::DLY_W-1:0] delay, next_delay;
   logic [seq_pkg::CNT_W-1:0] samples, next_samples;
   logic [seq_pkg::CHANS-1:0] seen, next_seen;
   logic go, next_go;
   logic pass_end;
   logic take;
   logic [seq_pkg::CHANS-1:0] chan_bit;
   logic [seq_pkg::CNT_W-1:0] samples_inc;

   // buffer
   logic [seq_pkg::DEPTH_W-1:0] wptr, next_wptr;
   logic [seq_pkg::DEPTH_W-1:0] rptr, next_rptr;
   logic [seq_pkg::DEPTH_W:0] buf_count, next_buf_count;
   logic [seq_pkg::DEPTH_W:0] buf_seen;
   logic overflow, next_overflow;
   logic mem_wr;
   logic pop;
   logic [seq_pkg::DATA_W-1:0] mem_rdata;

   // digital lines
   logic [seq_pkg::LINES-1:0] line_prev;
   logic [seq_pkg::LINES-1:0] in_mask;
   logic [seq_pkg::LINES-1:0] line_rise;
   logic arm_hit;
   logic trig_hit;
   logic [1:0] bank_out;
   logic [1:0] bank_act;
   logic [seq_pkg::LINES-1:0] next_line_out;
   logic [seq_pkg::LINES-1:0] next_line_oe;

   // one wait state: prdata is captured in the first access cycle
   assign wr = psel & penable & pready & pwrite;
   assign rd = psel & penable & pready & ~pwrite;

   always_comb begin
      hit = 1'b1;
      rd_word = 32'h0000_0000;
      case (paddr)
         seq_pkg::A_CONFIG: rd_word[seq_pkg::CFG_W-1:0] = cfg;
         seq_pkg::A_COMMAND: rd_word = 32'h0000_0000;
         seq_pkg::A_ARM_COUNT: rd_word[seq_pkg::CNT_W-1:0] = arm_count;
         seq_pkg::A_TRIGGER_PASS_COUNT: rd_word[seq_pkg::CNT_W-1:0] = trigger_pass_count;
         seq_pkg::A_ARM_DELAY: rd_word[seq_pkg::DLY_W-1:0] = arm_delay;
         seq_pkg::A_TRIG_DELAY: rd_word[seq_pkg::DLY_W-1:0] = trig_delay;
         seq_pkg::A_SAMPLE_COUNT: rd_word[seq_pkg::CNT_W-1:0] = sample_count;
         seq_pkg::A_SCAN_LIST: rd_word[seq_pkg::CHANS-1:0] = scan_list;
         seq_pkg::A_LINE_DRIVE: rd_word[seq_pkg::LINES-1:0] = line_drive;
         seq_pkg::A_ARM_SOURCE: rd_word[seq_pkg::LINES-1:0] = arm_source;
         seq_pkg::A_TRIG_SOURCE: rd_word[seq_pkg::LINES-1:0] = trig_source;
         seq_pkg::A_STATUS: rd_word = {overflow, buf_count, trig_left, arm_left, 5'h00, layer};
         seq_pkg::A_LINE_IN: rd_word[seq_pkg::LINES-1:0] = digital_line_in;
         seq_pkg::A_BUF_DATA: begin
            if (buf_seen != 7'h00) begin
               rd_word[seq_pkg::DATA_W-1:0] = mem_rdata;
            end
         end
         default: hit = 1'b0;
      endcase
      next_pready = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & ~hit;
      next_prdata = (psel & penable & ~pready) ? rd_word : prdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // register writes and command pulses
   assign cmd_init = wr & at(paddr, seq_pkg::A_COMMAND) & pwdata[seq_pkg::CMD_INIT];
   assign cmd_arm = wr & at(paddr, seq_pkg::A_COMMAND) & pwdata[seq_pkg::CMD_ARM];
   assign cmd_trig = wr & at(paddr, seq_pkg::A_COMMAND) & pwdata[seq_pkg::CMD_TRIG];

   always_comb begin
      next_cfg = cfg;
      next_arm_count = arm_count;
      next_trigger_pass_count = trigger_pass_count;
      next_arm_delay = arm_delay;
      next_trig_delay = trig_delay;
      next_sample_count = sample_count;
      next_scan_list = scan_list;
      next_line_drive = line_drive;
      next_arm_source = arm_source;
      next_trig_source = trig_source;
      if (wr) begin
         case (paddr)
            seq_pkg::A_CONFIG: next_cfg = pwdata[seq_pkg::CFG_W-1:0];
            seq_pkg::A_ARM_COUNT: next_arm_count = pwdata[seq_pkg::CNT_W-1:0];
            seq_pkg::A_TRIGGER_PASS_COUNT: next_trigger_pass_count = pwdata[seq_pkg::CNT_W-1:0];
            seq_pkg::A_ARM_DELAY: next_arm_delay = pwdata[seq_pkg::DLY_W-1:0];
            seq_pkg::A_TRIG_DELAY: next_trig_delay = pwdata[seq_pkg::DLY_W-1:0];
            seq_pkg::A_SAMPLE_COUNT: next_sample_count = pwdata[seq_pkg::CNT_W-1:0];
            seq_pkg::A_SCAN_LIST: next_scan_list = pwdata[seq_pkg::CHANS-1:0];
            seq_pkg::A_LINE_DRIVE: next_line_drive = pwdata[seq_pkg::LINES-1:0];
            seq_pkg::A_ARM_SOURCE: next_arm_source = pwdata[seq_pkg::LINES-1:0];
            seq_pkg::A_TRIG_SOURCE: next_trig_source = pwdata[seq_pkg::LINES-1:0];
            default: next_cfg = cfg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= seq_pkg::CONFIG_RST;
         arm_count <= seq_pkg::PASS_RST;
         trigger_pass_count <= seq_pkg::PASS_RST;
         arm_delay <= seq_pkg::DELAY_RST;
         trig_delay <= seq_pkg::DELAY_RST;
         sample_count <= seq_pkg::SAMPLE_RST;
         scan_list <= seq_pkg::SCAN_RST;
         line_drive <= seq_pkg::LINE_RST;
         arm_source <= seq_pkg::LINE_RST;
         trig_source <= seq_pkg::LINE_RST;
      end else begin
         cfg <= next_cfg;
         arm_count <= next_arm_count;
         trigger_pass_count <= next_trigger_pass_count;
         arm_delay <= next_arm_delay;
         trig_delay <= next_trig_delay;
         sample_count <= next_sample_count;
         scan_list <= next_scan_list;
         line_drive <= next_line_drive;
         arm_source <= next_arm_source;
         trig_source <= next_trig_source;
      end
   end

   // line events: rising edges on lines of input banks only
   assign bank_out = {cfg[seq_pkg::CFG_DIR1], cfg[seq_pkg::CFG_DIR0]};
   assign bank_act = {cfg[seq_pkg::CFG_ACT1], cfg[seq_pkg::CFG_ACT0]};
   assign in_mask = {{seq_pkg::BANK_W{~bank_out[1]}}, {seq_pkg::BANK_W{~bank_out[0]}}};
   assign line_rise = digital_line_in & ~line_prev & in_mask;
   assign arm_hit = |(line_rise & arm_source);
   assign trig_hit = |(line_rise & trig_source);

   always_comb begin
      for (int i = 0; i < seq_pkg::LINES; i++) begin
         // passive pull-up only sinks; active pull-up drives both levels
         next_line_oe[i] = bank_out[i / seq_pkg::BANK_W] & (bank_act[i / seq_pkg::BANK_W] | ~line_drive[i]);
         next_line_out[i] = bank_act[i / seq_pkg::BANK_W] & line_drive[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_prev <= 16'h0000;
         digital_line_out <= 16'h0000;
         digital_line_oe <= 16'h0000;
      end else begin
         line_prev <= digital_line_in;
         digital_line_out <= next_line_out;
         digital_line_oe <= next_line_oe;
      end
   end

   // sequencer
   assign chan_bit = 8'h01 << adc_chan;
   assign take = adc_valid & scan_list[adc_chan];
   assign samples_inc = samples + 8'h01;

   always_comb begin
      next_layer = layer;
      next_arm_left = arm_left;
      next_trig_left = trig_left;
      next_delay = delay;
      next_samples = samples;
      next_seen = seen;
      next_go = go;
      pass_end = 1'b0;
      unique case (layer)
         seq_pkg::IDLE: begin
            if (cmd_init) begin
               next_layer = seq_pkg::INIT;
               next_go = 1'b1;
            end
         end
         seq_pkg::INIT: begin
            next_go = 1'b0;
            if (go | cfg[seq_pkg::CFG_REARM]) begin
               next_layer = seq_pkg::ARM_WAIT;
               next_arm_left = arm_count;
            end else begin
               next_layer = seq_pkg::IDLE;
            end
         end
         seq_pkg::ARM_WAIT: begin
            if (arm_hit | cmd_arm) begin
               if (arm_delay == 16'h0000) begin
                  next_layer = seq_pkg::TRIG_WAIT;
                  next_arm_left = dec(arm_left);
                  next_trig_left = trigger_pass_count;
               end else begin
                  next_layer = seq_pkg::ARM_DELAY;
                  next_delay = arm_delay;
               end
            end
         end
         seq_pkg::ARM_DELAY: begin
            next_delay = delay - 16'h0001;
            if (delay == 16'h0001) begin
               next_layer = seq_pkg::TRIG_WAIT;
               next_arm_left = dec(arm_left);
               next_trig_left = trigger_pass_count;
            end
         end
         seq_pkg::TRIG_WAIT: begin
            if (trig_hit | cmd_trig) begin
               next_samples = 8'h00;
               next_seen = 8'h00;
               if (trig_delay == 16'h0000) begin
                  next_layer = seq_pkg::ACQUIRE;
                  next_trig_left = dec(trig_left);
               end else begin
                  next_layer = seq_pkg::TRIG_DELAY;
                  next_delay = trig_delay;
               end
            end
         end
         seq_pkg::TRIG_DELAY: begin
            next_delay = delay - 16'h0001;
            if (delay == 16'h0001) begin
               next_layer = seq_pkg::ACQUIRE;
               next_trig_left = dec(trig_left);
            end
         end
         seq_pkg::ACQUIRE: begin
            if (take) begin
               next_seen = seen | chan_bit;
               if ((seen | chan_bit) == scan_list) begin
                  next_seen = 8'h00;
                  next_samples = samples_inc;
                  pass_end = (samples_inc == sample_count);
               end
            end
            if (scan_list == 8'h00 || sample_count == 8'h00) begin
               pass_end = 1'b1;
            end
            if (pass_end) begin
               if (trig_left != 8'h00) begin
                  next_layer = seq_pkg::TRIG_WAIT;
               end else if (arm_left != 8'h00) begin
                  next_layer = seq_pkg::ARM_WAIT;
               end else begin
                  next_layer = seq_pkg::INIT;
               end
            end
         end
         default: next_layer = seq_pkg::IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         layer <= seq_pkg::IDLE;
         arm_left <= 8'h00;
         trig_left <= 8'h00;
         delay <= 16'h0000;
         samples <= 8'h00;
         seen <= 8'h00;
         go <= 1'b0;
      end else begin
         layer <= next_layer;
         arm_left <= next_arm_left;
         trig_left <= next_trig_left;
         delay <= next_delay;
         samples <= next_samples;
         seen <= next_seen;
         go <= next_go;
      end
   end

   // buffer: samples outside acquire never reach it
   assign mem_wr = (layer == seq_pkg::ACQUIRE) & take & (buf_count[seq_pkg::DEPTH_W] == 1'b0);
   assign pop = rd & at(paddr, seq_pkg::A_BUF_DATA) & (buf_seen != 7'h00);

   always_comb begin
      next_wptr = mem_wr ? wptr + 6'h01 : wptr;
      next_rptr = pop ? rptr + 6'h01 : rptr;
      next_buf_count = buf_count + {6'h00, mem_wr} - {6'h00, pop};
      next_overflow = overflow | ((layer == seq_pkg::ACQUIRE) & take & buf_count[seq_pkg::DEPTH_W]);
      if (layer == seq_pkg::IDLE && cmd_init) begin
         next_wptr = 6'h00;
         next_rptr = 6'h00;
         next_buf_count = 7'h00;
         next_overflow = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr <= 6'h00;
         rptr <= 6'h00;
         buf_count <= 7'h00;
         buf_seen <= 7'h00;
         overflow <= 1'b0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         buf_count <= next_buf_count;
         buf_seen <= buf_count; // lags a write until its word can be read
         overflow <= next_overflow;
      end
   end

   sample_mem store (
      .pclk(pclk),
      .wr_en(mem_wr),
      .wr_addr(wptr),
      .wr_data(adc_data),
      .rd_addr(rptr),
      .rd_data(mem_rdata)
   );

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence init_walk_s;
      layer == seq_pkg::INIT ##1 layer == seq_pkg::ARM_WAIT;
   endsequence
   sequence acq_to_trig_s;
      layer == seq_pkg::ACQUIRE ##1 layer == seq_pkg::TRIG_WAIT;
   endsequence

   idle_hold_a: assert property (layer == seq_pkg::IDLE && !cmd_init |=> layer == seq_pkg::IDLE)
      else $error("idle layer left without initialize");
   init_clear_a: assert property (layer == seq_pkg::IDLE && cmd_init |=> buf_count == 7'h00 ##0 init_walk_s)
      else $error("initialize did not clear buffer and reach arm");
   arm_reload_a: assert property (init_walk_s |-> arm_left == $past(arm_count))
      else $error("arm pass count not reloaded");
   arm_wait_a: assert property (layer == seq_pkg::ARM_WAIT && !arm_hit && !cmd_arm |=> layer == seq_pkg::ARM_WAIT)
      else $error("arm layer left without arm event");
   arm_step_a: assert property (layer == seq_pkg::ARM_DELAY && delay == 16'h0001 |=>
      layer == seq_pkg::TRIG_WAIT && arm_left == dec($past(arm_left)) && trig_left == $past(trigger_pass_count))
      else $error("arm delay exit wrong");
   trig_wait_a: assert property (layer == seq_pkg::TRIG_WAIT && !trig_hit && !cmd_trig |=> layer == seq_pkg::TRIG_WAIT)
      else $error("trigger layer left without trigger event");
   trig_step_a: assert property (layer == seq_pkg::TRIG_DELAY && delay == 16'h0001 |=>
      layer == seq_pkg::ACQUIRE && trig_left == dec($past(trig_left)))
      else $error("trigger delay exit wrong");
   trig_return_a: assert property (acq_to_trig_s |-> trig_left == $past(trig_left) && $past(trig_left) != 8'h00)
      else $error("trigger pass count reloaded after acquire");
   rearm_a: assert property (layer == seq_pkg::ACQUIRE && pass_end && trig_left == 8'h00 && arm_left != 8'h00
      |=> layer == seq_pkg::ARM_WAIT)
      else $error("arm layer not re-entered");
   idle_return_a: assert property (layer == seq_pkg::INIT && !go && !cfg[seq_pkg::CFG_REARM] |=> layer == seq_pkg::IDLE)
      else $error("init did not fall back to idle");
   discard_a: assert property (layer != seq_pkg::ACQUIRE |=> buf_count <= $past(buf_count))
      else $error("sample written outside acquire");
   bank_input_a: assert property (!cfg[seq_pkg::CFG_DIR0] |=> digital_line_oe[7:0] == 8'h00)
      else $error("input bank is driven");
endmodule

// ===== tb/event_source.sv
/* event_source: far-side model, converter results and external line events.
   assumes: runs on the bench clock; fire is a one-cycle request. */
`timescale 1ns/1ps
module event_source (
   // clock
   input wire logic pclk,
   // event request
   input wire logic fire,
   input wire logic [3:0] fire_line,
   // converter and lines
   output logic adc_valid,
   output logic [2:0] adc_chan,
   output logic [15:0] adc_data,
   output logic [15:0] ext_line
);
   initial begin
      adc_valid = 1'b0;
      adc_chan = 3'h0;
      adc_data = 16'h0000;
      ext_line = 16'h0000;
   end
   // results every other cycle, channels in turn; data never holds still
   always @(posedge pclk) begin
      adc_valid <= ~adc_valid;
      if (adc_valid) begin
         adc_chan <= adc_chan + 3'h1;
      end
      adc_data <= adc_data + 16'h1357;
      ext_line <= fire ? (16'h0001 << fire_line) : 16'h0000;
   end
endmodule

// ===== tb/testbench.sv
/* testbench: drives the sequencer over apb, checks layers, counts and lines.
   assumes: event_source supplies converter results and line events. */
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_valid, fire;
   logic [7:0] paddr, scan, samples;
   logic [31:0] pwdata, prdata, q, rnd;
   logic [2:0] adc_chan;
   logic [3:0] fire_line;
   logic [15:0] adc_data, ext_line, digital_line_out, digital_line_oe, drive;
   wire logic [15:0] digital_line_in = (digital_line_oe & digital_line_out) | (~digital_line_oe & ext_line);
   int err_count, tests_run, n;
   localparam logic [31:0] M = 32'h00FF0007;

   arm_trigger_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .adc_valid, .adc_chan, .adc_data, .digital_line_in, .digital_line_out, .digital_line_oe);
   event_source i_src (.pclk, .fire, .fire_line, .adc_valid, .adc_chan, .adc_data, .ext_line);

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic [31:0] fill(input logic [7:0] s, input logic [7:0] c);
      return (32'(c) * 32'($countones(s))) << 24;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      chk("apb answer", 32'h1, {31'h0, pready});
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
      for (int i = 0; i < 80; i++) begin
         apb(1'b0, seq_pkg::A_STATUS, 32'h0);
         if ((q & m) === v) break;
      end
      chk("status", v, q & m);
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, fire, paddr, pwdata, fire_line} = '0;
      err_count = 0;
      tests_run = 0;
      rnd = lfsr(32'h9C99);
      scan = rnd[7:0] | 8'h01;
      samples = {6'h0, rnd[9:8]} + 8'h01;
      drive = rnd[15:0];
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, seq_pkg::A_STATUS, 32'h0);
      chk("layer", 32'h0, q & M);
      chk("line oe", 32'h0, {16'h0, digital_line_oe});
      apb(1'b0, seq_pkg::A_ARM_COUNT, 32'h0);
      chk("arm count", 32'h1, q);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, pslverr});
      wr(seq_pkg::A_SCAN_LIST, {24'h0, scan});
      wr(seq_pkg::A_SAMPLE_COUNT, {24'h0, samples});
      wr(seq_pkg::A_ARM_COUNT, 32'h2);
      wr(seq_pkg::A_TRIGGER_PASS_COUNT, 32'h2);
      fire_line <= rnd[13:10];
      wr(seq_pkg::A_TRIG_SOURCE, 32'h1 << rnd[13:10]);
      wr(seq_pkg::A_COMMAND, 32'h1);
      wait_st(32'h7F00FF07, 32'h00000202);
      wr(seq_pkg::A_COMMAND, 32'h4);
      wait_st(32'h7, 32'h2);
      wr(seq_pkg::A_COMMAND, 32'h2);
      wait_st(32'h00FFFF07, 32'h00020104);
      @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      wait_st(M, 32'h00010004);
      chk("buffer fill", fill(scan, samples), q & 32'h7F000000);
      apb(1'b0, seq_pkg::A_BUF_DATA, 32'h0);
      chk("buffer data", 32'h1, {31'h0, (q[31:16] == 16'h0000) && (q[15:0] != 16'h0000)});
      apb(1'b0, seq_pkg::A_STATUS, 32'h0);
      chk("buffer pop", fill(scan, samples) - 32'h01000000, q & 32'h7F000000);
      wr(seq_pkg::A_COMMAND, 32'h4);
      wait_st(M, 32'h00000002);
      wr(seq_pkg::A_COMMAND, 32'h2);
      wait_st(M, 32'h00020004);
      wr(seq_pkg::A_COMMAND, 32'h4);
      wait_st(M, 32'h00010004);
      wr(seq_pkg::A_COMMAND, 32'h4);
      wait_st(32'h7, 32'h0);
      wr(seq_pkg::A_CONFIG, 32'h1);
      wr(seq_pkg::A_ARM_COUNT, 32'h1);
      wr(seq_pkg::A_TRIGGER_PASS_COUNT, 32'h1);
      wr(seq_pkg::A_ARM_DELAY, 32'h3);
      wr(seq_pkg::A_TRIG_DELAY, 32'h2);
      wr(seq_pkg::A_COMMAND, 32'h1);
      wait_st(32'h7, 32'h2);
      wr(seq_pkg::A_COMMAND, 32'h2);
      wait_st(M, 32'h00010004);
      wr(seq_pkg::A_COMMAND, 32'h4);
      wait_st(M, 32'h00000002);
      chk("buffer kept", fill(scan, samples), q & 32'h7F000000);
      wr(seq_pkg::A_CONFIG, 32'h16);
      wr(seq_pkg::A_LINE_DRIVE, {16'h0, drive});
      @(posedge pclk);
      @(negedge pclk);
      chk("line oe", {16'h0, 8'hFF, ~drive[7:0]}, {16'h0, digital_line_oe});
      chk("line out", {16'h0, drive[15:8], 8'h00}, {16'h0, digital_line_out});
      conclude();
   end
endmodule
